// >>> hw/net_config_defs.svh
/*
 Address map, field positions, reset values and timing of the
 common configuration block. Assumes a 100 MHz system clock.
*/
`ifndef NET_CONFIG_DEFS_SVH
`define NET_CONFIG_DEFS_SVH

// Byte addresses
`define ADDR_MODE      16'h0000
`define ADDR_SUBNET    16'h0005
`define ADDR_MAC       16'h0009
`define ADDR_IP        16'h000f
`define ADDR_CAUSE     16'h0015
`define ADDR_ENABLE    16'h0016
`define ADDR_RTIME     16'h0017
`define ADDR_RCOUNT    16'h0019
`define ADDR_AUTH      16'h001c
`define ADDR_ALGO      16'h001e
`define ADDR_VERSION   16'h001f
`define ADDR_LCP       16'h0028

// Field byte counts
`define SUBNET_BYTES   16'h0004
`define MAC_BYTES      16'h0006
`define IP_BYTES       16'h0004
`define RTIME_BYTES    16'h0002
`define AUTH_BYTES     16'h0002

// Bit positions
`define BIT_SW_RESET   7
`define BIT_PING_BLOCK 4
`define BIT_PPP_EN     3
`define BIT_CLASH      7
`define BIT_PPP_CLOSED 5

// Reset values and TCP wait cap
`define RTIME_RESET    16'h07d0
`define RCOUNT_RESET   8'h08
`define WAIT_MAX       17'h0ffff

// Timing
`define CLK_PERIOD_NS  10
`define RETRY_UNIT_US  100
`define LCP_UNIT_MS    25

`endif

// >>> hw/net_config_pkg.sv
/*
 Types of the common configuration block.
 Assumes nothing of its surroundings.
*/
package net_config_pkg;

   typedef enum logic [0:0] {
      RETRY_IDLE = 1'b0,
      RETRY_WAIT = 1'b1
   } retry_state_type;

   typedef struct packed {
      logic                  ppp_en;
      logic                  ping_block;
      logic [0:3][7:0]       subnet;
      logic [0:5][7:0]       mac;
      logic [0:3][7:0]       ip;
      logic                  cause_clash;
      logic                  cause_ppp;
      logic                  en_clash;
      logic                  en_ppp;
      logic [0:1][7:0]       retry_time;
      logic [7:0]            retry_count;
      logic [7:0]            lcp_interval;
      logic [0:1][7:0]       auth_type;
      logic [7:0]            auth_algo;
      logic [7:0]            rd_data;
      logic                  alert_n;
      retry_state_type       retry_state;
      logic                  is_tcp;
      logic [7:0]            attempts;
      logic [15:0]           wait_len;
      logic [15:0]           units;
      logic [15:0]           tick_cnt;
      logic                  retransmit;
      logic                  exhausted;
      logic                  close_sock;
      logic [21:0]           lcp_cycles;
      logic [7:0]            lcp_units;
      logic                  lcp_due;
   } block_state_type;

endpackage

// >>> hw/common_net_config_irq_retry.sv
/*
 Common configuration registers, host alert line and retry timer
 of a hardwired network controller.
 Assumes a byte-wide register port from the host interface and
 event pulses from protocol logic on the same clock.
*/
// The implementer's own choice: the strobed register port.
//
// What this block does
// - Six-byte MAC address, first byte on top
// - Four-byte IP address, top octet first
// - Four-byte subnet mask, top first, zero reset
// - ARP request with our IP sets clash
// - Clash and closed flags clear on one
// - PPPoE close sets bit five when enabled
// - Mode bit three enables PPPoE
// - Alert low while any enabled cause set
// - Enable bits gate matching cause bits
// - Retry time 16 bits, 100us, reset 2000
// - Retry time two bytes sets timeout
// - Retransmit when peer late or silent
// - Retry count reset 8, exhaust after count+1
// - TCP exhaust also closes the socket
// - ARP resent each retry time interval
// - ARP timeout is time times count+1
// - TCP wait doubles, capped below 65536
// - Read-only auth type, zero reset
// - Read-only auth algorithm, zero reset
// - Fixed chip version on read
// - LCP echo interval in 25ms counts
`timescale 1ns/1ps
`include "net_config_defs.svh"

module common_net_config_irq_retry
   import net_config_pkg::*;
#(
   // Value is arbitrary
   parameter logic [7:0] CHIP_VERSION      = 8'h5a,
   parameter int         RETRY_UNIT_CYCLES =
      `RETRY_UNIT_US * 1000 / `CLK_PERIOD_NS,
   parameter int         LCP_UNIT_CYCLES   =
      `LCP_UNIT_MS * 1000000 / `CLK_PERIOD_NS
)(
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [7:0]  reg_rdata,
   input  wire logic        arp_req_seen,
   input  wire logic [31:0] arp_req_ip,
   input  wire logic        ppp_link_closed,
   input  wire logic [15:0] negotiated_auth_type,
   input  wire logic [7:0]  negotiated_auth_algo,
   input  wire logic        retry_start,
   input  wire logic        retry_is_tcp,
   input  wire logic        peer_response,
   output logic             host_alert_n,
   output logic      [47:0] local_mac_address,
   output logic      [31:0] local_ip_address,
   output logic      [31:0] subnet_mask,
   output logic             ppp_mode_enable,
   output logic             ping_block_enable,
   output logic             retransmit_request,
   output logic             retry_exhausted,
   output logic             socket_close_request,
   output logic             lcp_echo_due
);

   block_state_type st_reg;
   block_state_type st_next;
   logic            sw_reset_hit;
   logic            clr_clash;
   logic            clr_ppp;
   logic            unit_tick;

   ////////////////////////////////////////////////////////////////
   // Helpers

   // Value of the whole state after reset
   function automatic block_state_type state_at_reset();
      block_state_type s;
      s = '0;
      s.retry_time  = `RTIME_RESET;
      s.retry_count = `RCOUNT_RESET;
      s.alert_n     = 1'b1;
      s.retry_state = RETRY_IDLE;
      return s;
   endfunction

   // Address falls inside a multi-byte field
   function automatic logic hit(input logic [15:0] a,
                                input logic [15:0] base,
                                input logic [15:0] n);
      return (a >= base) && (a < base + n);
   endfunction

   // Byte index inside a multi-byte field
   function automatic logic [2:0] ofs(input logic [15:0] a,
                                      input logic [15:0] base);
      logic [15:0] d;
      d = a - base;
      return d[2:0];
   endfunction

   // Next TCP wait: double, hold once it would pass the cap
   function automatic logic [15:0] dbl(input logic [15:0] w);
      logic [16:0] d;
      d = {w, 1'b0};
      if (d > `WAIT_MAX) begin
         return w;
      end
      return d[15:0];
   endfunction

   ////////////////////////////////////////////////////////////////
   // Next state

   assign sw_reset_hit = reg_write && (reg_addr == `ADDR_MODE) &&
                         reg_wdata[`BIT_SW_RESET];
   assign clr_clash = reg_write && (reg_addr == `ADDR_CAUSE) &&
                      reg_wdata[`BIT_CLASH];
   assign clr_ppp = reg_write && (reg_addr == `ADDR_CAUSE) &&
                    reg_wdata[`BIT_PPP_CLOSED];
   assign unit_tick = st_reg.tick_cnt ==
                      16'(RETRY_UNIT_CYCLES - 1);

   always_comb begin
      st_next = st_reg;
      st_next.rd_data    = 8'h00;
      st_next.retransmit = 1'b0;
      st_next.exhausted  = 1'b0;
      st_next.close_sock = 1'b0;
      st_next.lcp_due    = 1'b0;
      st_next.auth_type  = negotiated_auth_type;
      st_next.auth_algo  = negotiated_auth_algo;

      // Host writes to plain storage
      if (reg_write) begin
         if (hit(reg_addr, `ADDR_SUBNET, `SUBNET_BYTES)) begin
            st_next.subnet[ofs(reg_addr, `ADDR_SUBNET)] =
               reg_wdata;
         end
         if (hit(reg_addr, `ADDR_MAC, `MAC_BYTES)) begin
            st_next.mac[ofs(reg_addr, `ADDR_MAC)] =
               reg_wdata;
         end
         if (hit(reg_addr, `ADDR_IP, `IP_BYTES)) begin
            st_next.ip[ofs(reg_addr, `ADDR_IP)] =
               reg_wdata;
         end
         if (hit(reg_addr, `ADDR_RTIME, `RTIME_BYTES)) begin
            st_next.retry_time[ofs(reg_addr, `ADDR_RTIME)] =
               reg_wdata;
         end
         case (reg_addr)
            `ADDR_MODE: begin
               st_next.ppp_en = reg_wdata[`BIT_PPP_EN];
               st_next.ping_block = reg_wdata[`BIT_PING_BLOCK];
            end
            `ADDR_ENABLE: begin
               // Only two enable bits exist
               st_next.en_clash = reg_wdata[`BIT_CLASH];
               st_next.en_ppp   = reg_wdata[`BIT_PPP_CLOSED];
            end
            `ADDR_RCOUNT: st_next.retry_count = reg_wdata;
            `ADDR_LCP:    st_next.lcp_interval = reg_wdata;
            default: ;
         endcase
      end

      // Sticky causes: a new event wins over a clear
      st_next.cause_clash = (st_reg.cause_clash & ~clr_clash) |
         (arp_req_seen && (arp_req_ip == st_reg.ip));
      st_next.cause_ppp = (st_reg.cause_ppp & ~clr_ppp) |
         (ppp_link_closed && st_reg.ppp_en);

      // Host reads, answered in the following cycle
      if (reg_read) begin
         if (hit(reg_addr, `ADDR_SUBNET, `SUBNET_BYTES)) begin
            st_next.rd_data = st_reg.subnet[ofs(reg_addr,
                                                `ADDR_SUBNET)];
         end
         if (hit(reg_addr, `ADDR_MAC, `MAC_BYTES)) begin
            st_next.rd_data = st_reg.mac[ofs(reg_addr, `ADDR_MAC)];
         end
         if (hit(reg_addr, `ADDR_IP, `IP_BYTES)) begin
            st_next.rd_data = st_reg.ip[ofs(reg_addr, `ADDR_IP)];
         end
         if (hit(reg_addr, `ADDR_RTIME, `RTIME_BYTES)) begin
            st_next.rd_data = st_reg.retry_time[ofs(reg_addr,
                                                    `ADDR_RTIME)];
         end
         if (hit(reg_addr, `ADDR_AUTH, `AUTH_BYTES)) begin
            st_next.rd_data = st_reg.auth_type[ofs(reg_addr,
                                                   `ADDR_AUTH)];
         end
         case (reg_addr)
            `ADDR_MODE: begin
               st_next.rd_data[`BIT_PPP_EN] = st_reg.ppp_en;
               st_next.rd_data[`BIT_PING_BLOCK] = st_reg.ping_block;
            end
            `ADDR_CAUSE: begin
               // Reserved bits stay zero
               st_next.rd_data[`BIT_CLASH] = st_reg.cause_clash;
               st_next.rd_data[`BIT_PPP_CLOSED] = st_reg.cause_ppp;
            end
            `ADDR_ENABLE: begin
               st_next.rd_data[`BIT_CLASH] = st_reg.en_clash;
               st_next.rd_data[`BIT_PPP_CLOSED] = st_reg.en_ppp;
            end
            `ADDR_RCOUNT:  st_next.rd_data = st_reg.retry_count;
            `ADDR_ALGO:    st_next.rd_data = st_reg.auth_algo;
            `ADDR_VERSION: st_next.rd_data = CHIP_VERSION;
            `ADDR_LCP:     st_next.rd_data = st_reg.lcp_interval;
            default: ;
         endcase
      end

      // Retransmission timer, counted in retry-time units
      case (st_reg.retry_state)
         RETRY_IDLE: ;
         RETRY_WAIT: begin
            if (peer_response) begin
               st_next.retry_state = RETRY_IDLE;
            end else if (!unit_tick) begin
               st_next.tick_cnt = st_reg.tick_cnt + 16'h0001;
            end else begin
               st_next.tick_cnt = 16'h0000;
               if (st_reg.units > 16'h0001) begin
                  st_next.units = st_reg.units - 16'h0001;
               end else if (st_reg.attempts ==
                            st_reg.retry_count) begin
                  // Final timeout
                  st_next.exhausted   = 1'b1;
                  st_next.close_sock  = st_reg.is_tcp;
                  st_next.retry_state = RETRY_IDLE;
               end else begin
                  // Resend; ARP keeps its wait
                  st_next.retransmit = 1'b1;
                  st_next.attempts = st_reg.attempts + 8'h01;
                  if (st_reg.is_tcp) begin
                     st_next.wait_len = dbl(st_reg.wait_len);
                  end
                  st_next.units = st_next.wait_len;
               end
            end
         end
         default: st_next.retry_state = RETRY_IDLE;
      endcase
      if (retry_start) begin
         st_next.retry_state = RETRY_WAIT;
         st_next.is_tcp      = retry_is_tcp;
         st_next.attempts    = 8'h00;
         st_next.wait_len    = st_reg.retry_time;
         st_next.units       = st_reg.retry_time;
         st_next.tick_cnt    = 16'h0000;
      end

      // LCP echo pacing while PPPoE is on
      if (!st_reg.ppp_en || st_reg.lcp_interval == 8'h00) begin
         st_next.lcp_cycles = 22'h000000;
         st_next.lcp_units  = 8'h00;
      end else if (st_reg.lcp_cycles !=
                   22'(LCP_UNIT_CYCLES - 1)) begin
         st_next.lcp_cycles = st_reg.lcp_cycles + 22'h000001;
      end else begin
         st_next.lcp_cycles = 22'h000000;
         if (st_reg.lcp_units + 8'h01 >= st_reg.lcp_interval) begin
            st_next.lcp_units = 8'h00;
            st_next.lcp_due   = 1'b1;
         end else begin
            st_next.lcp_units = st_reg.lcp_units + 8'h01;
         end
      end

      // Self-clearing software reset of the whole block
      if (sw_reset_hit) begin
         st_next = state_at_reset();
      end

      // Alert line from the next causes and enables
      st_next.alert_n = !((st_next.cause_clash && st_next.en_clash)
                       || (st_next.cause_ppp && st_next.en_ppp));
   end

   ////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_reg <= state_at_reset();
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state flip-flops
   assign reg_rdata            = st_reg.rd_data;
   assign host_alert_n         = st_reg.alert_n;
   assign local_mac_address    = st_reg.mac;
   assign local_ip_address     = st_reg.ip;
   assign subnet_mask          = st_reg.subnet;
   assign ppp_mode_enable      = st_reg.ppp_en;
   assign ping_block_enable    = st_reg.ping_block;
   assign retransmit_request   = st_reg.retransmit;
   assign retry_exhausted      = st_reg.exhausted;
   assign socket_close_request = st_reg.close_sock;
   assign lcp_echo_due         = st_reg.lcp_due;

   ////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_mac_first_byte: assert property (
      reg_write && reg_addr == `ADDR_MAC |=>
      local_mac_address[47 -: 8] == $past(reg_wdata))
      else $error("MAC first byte not stored at top");

   a_ip_last_octet: assert property (
      reg_write && reg_addr == `ADDR_IP + 16'h0003 |=>
      local_ip_address[7:0] == $past(reg_wdata))
      else $error("IP low octet not at highest address");

   a_subnet_top: assert property (
      reg_write && reg_addr == `ADDR_SUBNET |=>
      subnet_mask[31 -: 8] == $past(reg_wdata))
      else $error("Subnet first octet misplaced");

   a_clash_set: assert property (
      arp_req_seen && arp_req_ip == local_ip_address &&
      !sw_reset_hit |=> st_reg.cause_clash &&
      (!host_alert_n || !st_reg.en_clash))
      else $error("Address clash not flagged");

   a_clash_hold: assert property (
      st_reg.cause_clash && !clr_clash && !sw_reset_hit |=>
      st_reg.cause_clash)
      else $error("Clash flag lost without a one write");

   a_ppp_gate: assert property (
      !st_reg.ppp_en && !st_reg.cause_ppp && !clr_ppp |=>
      !st_reg.cause_ppp)
      else $error("PPPoE close flagged while disabled");

   a_alert_level: assert property (
      host_alert_n == !((st_reg.cause_clash && st_reg.en_clash) ||
      (st_reg.cause_ppp && st_reg.en_ppp)))
      else $error("Alert line disagrees with causes");

   a_first_wait: assert property (
      retry_start && !sw_reset_hit |=>
      st_reg.units == $past(st_reg.retry_time) &&
      st_reg.attempts == 8'h00)
      else $error("Retry wait not loaded from retry time");

   a_wait_double: assert property (
      retransmit_request && st_reg.is_tcp |->
      st_reg.wait_len == dbl($past(st_reg.wait_len)))
      else $error("TCP wait did not double or hold");

   a_exhaust_count: assert property (
      retry_exhausted |->
      $past(st_reg.attempts) == $past(st_reg.retry_count))
      else $error("Exhausted before count plus one waits");

   a_tcp_close: assert property (
      retry_exhausted |-> socket_close_request == st_reg.is_tcp)
      else $error("Close request does not match socket type");

   a_version_read: assert property (
      reg_read && reg_addr == `ADDR_VERSION |=>
      reg_rdata == CHIP_VERSION)
      else $error("Chip version read wrong");

endmodule

// >>> verification/host_model.sv
/*
 Host side model of the byte register port.
 Assumes one clock; the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps

module host_model (
   input  wire logic        sys_clk,
   output logic      [15:0] reg_addr,
   output logic      [7:0]  reg_wdata,
   output logic             reg_write,
   output logic             reg_read
);

   // Idle bus from time zero
   initial begin
      reg_addr  = 16'h0000;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read  = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // One write cycle; stale data inverted once no longer qualified
   task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      reg_wdata <= ~d;
   endtask

   // One read cycle; the bench monitor takes the data a cycle later
   task automatic read_reg(input logic [15:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
   endtask

endmodule

// >>> verification/common_net_config_irq_retry_bench.sv
/*
 Self-checking bench of the common configuration block.
 Assumes the host model drives the register port; short unit counts.
*/
`timescale 1ns/1ps
`include "net_config_defs.svh"

module common_net_config_irq_retry_bench;

   localparam int         UNIT = 4;
   localparam logic [7:0] VER  = 8'h3c; // Value is arbitrary

   logic        sys_clk, reset, reg_write, reg_read, rd_seen;
   logic [15:0] reg_addr, auth;
   logic [7:0]  reg_wdata, reg_rdata, algo, b;
   logic        arp_req_seen, ppp_link_closed, retry_start;
   logic        retry_is_tcp, peer_response, host_alert_n;
   logic [31:0] arp_req_ip, ip, subnet;
   logic [47:0] mac, ex[3];
   logic        ppp_en, ping_blk, rt_req, rt_ex, rt_cl, lcp_due;
   logic [7:0]  exp_q[$];
   int          iv_q[$];
   int          mismatches, n_checks, cyc, last_ev, n_rt, n_ex, n_cl;
   int          t, k;
   logic [15:0] base[3] = '{`ADDR_MAC, `ADDR_IP, `ADDR_SUBNET};
   int          nb[3]   = '{6, 4, 4};

   host_model i_host (.sys_clk(sys_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));

   common_net_config_irq_retry #(.CHIP_VERSION(VER),
      .RETRY_UNIT_CYCLES(UNIT), .LCP_UNIT_CYCLES(UNIT)) i_dut (
      .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .arp_req_seen(arp_req_seen),
      .arp_req_ip(arp_req_ip), .ppp_link_closed(ppp_link_closed),
      .negotiated_auth_type(auth), .negotiated_auth_algo(algo),
      .retry_start(retry_start), .retry_is_tcp(retry_is_tcp),
      .peer_response(peer_response), .host_alert_n(host_alert_n),
      .local_mac_address(mac), .local_ip_address(ip),
      .subnet_mask(subnet), .ppp_mode_enable(ppp_en),
      .ping_block_enable(ping_blk), .retransmit_request(rt_req),
      .retry_exhausted(rt_ex), .socket_close_request(rt_cl),
      .lcp_echo_due(lcp_due));

   // Free-running 100 MHz clock
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (mismatches == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask

   // Note the expected byte, then read it
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_host.read_reg(a);
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      i_host.write_reg(a, d);
      #1;
   endtask

   // One-cycle protocol event: address clash or link closed
   task automatic ev(input logic clash, input logic [31:0] a);
      @(posedge sys_clk);
      arp_req_seen    <= clash;
      arp_req_ip      <= a;
      ppp_link_closed <= !clash;
      @(posedge sys_clk);
      arp_req_seen    <= 1'b0;
      ppp_link_closed <= 1'b0;
      arp_req_ip      <= ~a;
      #1;
   endtask

   // Start a wait, optionally answer it, then watch for n cycles
   task automatic retry_run(input logic tcp, input logic resp,
                            input int n);
      iv_q.delete();
      n_rt = 0;
      n_ex = 0;
      n_cl = 0;
      @(posedge sys_clk);
      retry_start  <= 1'b1;
      retry_is_tcp <= tcp;
      @(posedge sys_clk);
      retry_start  <= 1'b0;
      retry_is_tcp <= ~tcp;
      repeat (2) @(posedge sys_clk);
      peer_response <= resp;
      @(posedge sys_clk);
      peer_response <= 1'b0;
      repeat (n) @(posedge sys_clk);
   endtask

   // Edges until the next echo pulse, bounded
   task automatic wait_lcp(output int e);
      e = 0;
      do begin
         @(posedge sys_clk);
         e++;
      end while (lcp_due !== 1'b1 && e < 100);
   endtask

   ////////////////////////////////////////////////////////////////////
   // Output monitor: read data, retry pulses and the run limit
   always @(posedge sys_clk) begin
      cyc++;
      rd_seen <= reg_read;
      if (rd_seen === 1'b1) begin
         chk(reg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
      end
      if (retry_start === 1'b1) last_ev = cyc;
      if (rt_req === 1'b1 || rt_ex === 1'b1) begin
         iv_q.push_back(cyc - last_ev);
         last_ev = cyc;
      end
      if (rt_req === 1'b1) n_rt++;
      if (rt_ex === 1'b1) n_ex++;
      if (rt_cl === 1'b1) n_cl++;
      if (cyc > 5000) begin
         mismatches++;
         report_and_stop();
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      reset = 1'b1;
      {arp_req_seen, ppp_link_closed, retry_start} = 3'h0;
      {retry_is_tcp, peer_response} = 2'h0;
      arp_req_ip = 32'h0;
      auth = 16'h0000;
      algo = 8'h00;
      void'($urandom(1));
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      // Reset values and read-only places
      rd(`ADDR_RTIME, 8'h07);
      rd(`ADDR_RTIME + 16'h0001, 8'hd0);
      rd(`ADDR_RCOUNT, 8'h08);
      rd(`ADDR_AUTH, 8'h00);
      rd(`ADDR_ALGO, 8'h00);
      rd(`ADDR_VERSION, VER);
      wr(16'h0013, 8'hff);
      rd(16'h0013, 8'h00);
      // Address fields with random bytes, top byte at lowest address
      for (int f = 0; f < 3; f++) begin
         ex[f] = 48'h0;
         for (int i = 0; i < nb[f]; i++) begin
            b = 8'($urandom);
            ex[f] = {ex[f][39:0], b};
            wr(base[f] + 16'(i), b);
            exp_q.push_back(b);
            i_host.read_reg(base[f] + 16'(i));
         end
      end
      chk(mac, ex[0]);
      chk({16'h0, ip}, ex[1]);
      chk({16'h0, subnet}, ex[2]);
      // Negotiated results reach the read-only registers
      for (int i = 0; i < 2; i++) begin
         auth <= i ? 16'hc223 : 16'hc023;
         algo <= 8'($urandom);
         wr(`ADDR_AUTH, 8'h5a);
         rd(`ADDR_AUTH, i ? 8'hc2 : 8'hc0);
         rd(`ADDR_AUTH + 16'h0001, 8'h23);
         rd(`ADDR_ALGO, algo);
      end
      // Reserved enable and cause bits
      wr(`ADDR_ENABLE, 8'hff);
      rd(`ADDR_ENABLE, 8'ha0);
      wr(`ADDR_CAUSE, 8'hff);
      rd(`ADDR_CAUSE, 8'h00);
      // Address clash
      ev(1'b1, ex[1][31:0] ^ 32'h1);
      chk(host_alert_n, 1'b1);
      ev(1'b1, ex[1][31:0]);
      chk(host_alert_n, 1'b0);
      rd(`ADDR_CAUSE, 8'h80);
      wr(`ADDR_CAUSE, 8'h00);
      rd(`ADDR_CAUSE, 8'h80);
      wr(`ADDR_CAUSE, 8'h80);
      chk(host_alert_n, 1'b1);
      // Link closed, first with the mode off
      ev(1'b0, 32'h0);
      rd(`ADDR_CAUSE, 8'h00);
      wr(`ADDR_MODE, 8'h08);
      chk(ppp_en, 1'b1);
      ev(1'b0, 32'h0);
      chk(host_alert_n, 1'b0);
      rd(`ADDR_CAUSE, 8'h20);
      wr(`ADDR_ENABLE, 8'h00);
      chk(host_alert_n, 1'b1);
      ev(1'b1, ex[1][31:0]);
      chk(host_alert_n, 1'b1);
      rd(`ADDR_CAUSE, 8'ha0);
      wr(`ADDR_CAUSE, 8'ha0);
      rd(`ADDR_CAUSE, 8'h00);
      // Echo interval of three units
      wr(`ADDR_LCP, 8'h03);
      rd(`ADDR_LCP, 8'h03);
      wait_lcp(t);
      wait_lcp(t);
      chk(t, 3 * UNIT);
      wr(`ADDR_MODE, 8'h00);
      // Waits of two units, two retransmits, then exhausted
      wr(`ADDR_RTIME, 8'h00);
      wr(`ADDR_RTIME + 16'h0001, 8'h02);
      wr(`ADDR_RCOUNT, 8'h02);
      retry_run(1'b0, 1'b0, 6 * UNIT + 20);
      chk(n_rt, 2);
      chk({n_ex, n_cl}, {32'd1, 32'd0});
      chk(iv_q[0] >= 2 * UNIT && iv_q[0] <= 2 * UNIT + 2, 1);
      chk({iv_q[1], iv_q[2]}, {2 * UNIT, 2 * UNIT});
      // Doubling waits of 3, 6, 12, 24 units, socket closed
      wr(`ADDR_RTIME + 16'h0001, 8'h03);
      wr(`ADDR_RCOUNT, 8'h03);
      retry_run(1'b1, 1'b0, 45 * UNIT + 20);
      chk(n_rt, 3);
      chk({n_ex, n_cl}, {32'd1, 32'd1});
      for (k = 1; k < 4; k++) begin
         chk(iv_q[k], (3 << k) * UNIT);
      end
      // Peer answers in time, nothing is resent
      retry_run(1'b1, 1'b1, 60);
      chk({n_rt, n_ex}, 64'h0);
      // Ping block bit, then a software reset of the whole block
      wr(`ADDR_MODE, 8'h10);
      chk(ping_blk, 1'b1);
      wr(`ADDR_MODE, 8'h80);
      chk({ping_blk, mac}, 49'h0);
      rd(`ADDR_RCOUNT, 8'h08);
      rd(`ADDR_MODE, 8'h00);
      repeat (3) @(posedge sys_clk);
      report_and_stop();
   end

endmodule
